// ===== hdl/branch_unit_pkg.sv
/*
  Shared constants for the branch and bit-test execution unit: opcodes,
  register offsets, flag positions, reset values and the state type.
  Assumes a 16-bit address space and a byte-wide program/data memory.
*/
package branch_unit_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_ALWAYS = 8'h20;
  localparam logic [7:0] OP_NEVER = 8'h21;
  localparam logic [7:0] OP_UHIGHER = 8'h22;
  localparam logic [7:0] OP_PLUS = 8'h2a;
  localparam logic [7:0] OP_SGREATER = 8'h2e;
  localparam logic [3:0] REL_GROUP = 4'h2;
  localparam logic [3:0] MODE_DIR = 4'h4;
  localparam logic [3:0] MODE_EXT = 4'h1;
  localparam logic [3:0] MODE_IDX = 4'h0;
  localparam logic [3:0] LO_CLEARED = 4'hf;
  localparam logic [3:0] LO_SET = 4'he;
  localparam logic [3:0] LO_BITSET = 4'hc;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PC = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_INDEX = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_GO = 0;
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_TAKEN = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_FETCH_LSB = 4;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int TAKEN_FETCHES_DEF = 3;
  localparam logic [3:0] UNTAKEN_FETCHES = 4'h1;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EVAL, S_READ, S_WRITE, S_QUEUE} exec_state_t;
endpackage : branch_unit_pkg

// ===== hdl/branch_unit.sv
/*
  Branch and bit-test execution unit with an APB register port and a
  byte-wide memory master port. Assumes memory logic on pclk that answers
  each held request with a one-cycle mem_ack.
*/
// Notes on behaviour
// - plus branch taken when N clear, flags kept
// - branch always loads PC plus two plus offset
// - offset is second byte, signed
// - taken branch refills queue from target
// - branch always uses TAKEN_FETCHES program fetches, three by default
// - branch never only adds two to PC
// - branch never does one program fetch
// - bits-cleared branches when masked byte zero
// - bits-set branches when inverted masked byte zero
// - test mask sits two, three or four bytes on
// - bit-test target follows last offset byte
// - indirect indexed forms are refused
// - bit set writes byte ORed with mask
// - set mask sits two to four bytes on
// - signed conditions use Z, N xor V
// - unsigned conditions use C, C or Z
`timescale 1ns/100ps
module branch_unit #(
  parameter int TAKEN_FETCHES = branch_unit_pkg::TAKEN_FETCHES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_qfill,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  // ==========================================================
  // Elaboration check
  generate
    if (TAKEN_FETCHES < 1 || TAKEN_FETCHES > 15) begin : g_bad_fetches
      $error("TAKEN_FETCHES must be 1 to 15");
    end
  endgenerate

  localparam logic [3:0] TAKEN_CNT = 4'(TAKEN_FETCHES);

  branch_unit_pkg::exec_state_t state_r;
  logic [7:0] buf_r [0:5];
  logic [2:0] cnt_r, len_r, len_now;
  logic bad_now;
  logic [15:0] pc_r, index_r, qaddr_r;
  logic [7:0] flags_r, data_r;
  logic [3:0] qleft_r, pfetch_r;
  logic busy_r, taken_r, illegal_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic mem_req_r, mem_we_r, mem_qfill_r;
  logic [15:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic wr_acc, rd_acc, ack_now;
  logic [7:0] op, xb, mask, rel;
  logic is_bsetop, cond_ok, bits_ok;
  logic [15:0] ea, rel_ext, target, seq_pc;

  // ==========================================================
  // APB slave: one wait state, answer on the second access cycle
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign rd_acc = psel & penable & ~pready_r & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & (paddr > branch_unit_pkg::REG_STATUS
                   || paddr[1:0] != 2'b00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        branch_unit_pkg::REG_PC: prdata_r <= {16'h0000, pc_r};
        branch_unit_pkg::REG_FLAGS: prdata_r <= {24'h00_0000, flags_r};
        branch_unit_pkg::REG_INDEX: prdata_r <= {16'h0000, index_r};
        branch_unit_pkg::REG_STATUS: prdata_r <= {24'h00_0000, pfetch_r, 1'b0, illegal_r,
                                                  taken_r, busy_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Flags and index base only change by software, and not mid-instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= branch_unit_pkg::FLAGS_RESET;
      index_r <= branch_unit_pkg::INDEX_RESET;
    end else if (wr_acc && !busy_r) begin
      if (paddr == branch_unit_pkg::REG_FLAGS) begin
        flags_r <= pwdata[7:0];
      end
      if (paddr == branch_unit_pkg::REG_INDEX) begin
        index_r <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Instruction decode
  assign op = buf_r[0];
  assign xb = buf_r[1];
  assign ack_now = mem_req_r & mem_ack;
  assign is_bsetop = (op[3:0] == branch_unit_pkg::LO_BITSET);
  assign mask = is_bsetop ? buf_r[len_r - 3'd1] : buf_r[len_r - 3'd2];
  assign rel = buf_r[len_r - 3'd1];
  assign rel_ext = {{8{rel[7]}}, rel};
  assign seq_pc = pc_r + {13'h0000, len_r};
  assign target = seq_pc + rel_ext;

  always_comb begin
    len_now = len_r;
    bad_now = 1'b0;
    if (cnt_r == 3'd0) begin
      if (mem_rdata[7:4] == branch_unit_pkg::REL_GROUP) begin
        len_now = 3'd2;
      end else if ((mem_rdata[7:4] == branch_unit_pkg::MODE_DIR
                    || mem_rdata[7:4] == branch_unit_pkg::MODE_EXT
                    || mem_rdata[7:4] == branch_unit_pkg::MODE_IDX)
                   && (mem_rdata[3:0] == branch_unit_pkg::LO_CLEARED
                    || mem_rdata[3:0] == branch_unit_pkg::LO_SET
                    || mem_rdata[3:0] == branch_unit_pkg::LO_BITSET)) begin
        len_now = (mem_rdata[1] ? 3'd3 : 3'd2)
                + (mem_rdata[7:4] == branch_unit_pkg::MODE_EXT ? 3'd2 : 3'd1);
      end else begin
        bad_now = 1'b1;
      end
    end else if (cnt_r == 3'd1 && op[7:4] == branch_unit_pkg::MODE_IDX) begin
      if (!mem_rdata[5]) begin
        len_now = len_r;
      end else if (mem_rdata[7:5] == 3'b111 && mem_rdata[2:1] == 2'b00) begin
        len_now = len_r + 3'd1;
      end else if (mem_rdata[7:5] == 3'b111 && mem_rdata[2:0] == 3'b010) begin
        len_now = len_r + 3'd2;
      end else begin
        bad_now = 1'b1;
      end
    end
  end

  always_comb begin
    case (op[7:4])
      branch_unit_pkg::MODE_DIR: ea = {8'h00, buf_r[1]};
      branch_unit_pkg::MODE_EXT: ea = {buf_r[1], buf_r[2]};
      default: begin
        if (!xb[5]) begin
          ea = index_r + {{11{xb[4]}}, xb[4:0]};
        end else if (!xb[1]) begin
          ea = index_r + {{8{xb[0]}}, buf_r[2]};
        end else begin
          ea = index_r + {buf_r[2], buf_r[3]};
        end
      end
    endcase
  end

  always_comb begin
    case (op[3:0])
      4'h0: cond_ok = 1'b1;
      4'h1: cond_ok = 1'b0;
      4'h2: cond_ok = ~(flags_r[branch_unit_pkg::FLG_C] | flags_r[branch_unit_pkg::FLG_Z]);
      4'h3: cond_ok = flags_r[branch_unit_pkg::FLG_C] | flags_r[branch_unit_pkg::FLG_Z];
      4'h4: cond_ok = ~flags_r[branch_unit_pkg::FLG_C];
      4'h5: cond_ok = flags_r[branch_unit_pkg::FLG_C];
      4'h6: cond_ok = ~flags_r[branch_unit_pkg::FLG_Z];
      4'h7: cond_ok = flags_r[branch_unit_pkg::FLG_Z];
      4'h8: cond_ok = ~flags_r[branch_unit_pkg::FLG_V];
      4'h9: cond_ok = flags_r[branch_unit_pkg::FLG_V];
      4'ha: cond_ok = ~flags_r[branch_unit_pkg::FLG_N];
      4'hb: cond_ok = flags_r[branch_unit_pkg::FLG_N];
      4'hc: cond_ok = ~(flags_r[branch_unit_pkg::FLG_N] ^ flags_r[branch_unit_pkg::FLG_V]);
      4'hd: cond_ok = flags_r[branch_unit_pkg::FLG_N] ^ flags_r[branch_unit_pkg::FLG_V];
      4'he: cond_ok = ~(flags_r[branch_unit_pkg::FLG_Z]
                       | (flags_r[branch_unit_pkg::FLG_N] ^ flags_r[branch_unit_pkg::FLG_V]));
      default: cond_ok = flags_r[branch_unit_pkg::FLG_Z]
                       | (flags_r[branch_unit_pkg::FLG_N] ^ flags_r[branch_unit_pkg::FLG_V]);
    endcase
  end

  assign bits_ok = (op[3:0] == branch_unit_pkg::LO_CLEARED) ? ((mem_rdata & mask) == 8'h00)
                                                         : ((~mem_rdata & mask) == 8'h00);

  // ==========================================================
  // Sequencer: fetch bytes, read/modify memory, resolve, refill queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= branch_unit_pkg::S_IDLE;
      pc_r <= branch_unit_pkg::PC_RESET;
      cnt_r <= 3'd0;
      len_r <= 3'd0;
      for (int i = 0; i < 6; i++) begin
        buf_r[i] <= 8'h00;
      end
      busy_r <= 1'b0;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
      qaddr_r <= 16'h0000;
      qleft_r <= 4'h0;
      pfetch_r <= 4'h0;
      data_r <= 8'h00;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_qfill_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 8'h00;
    end else begin
      case (state_r)
        branch_unit_pkg::S_IDLE: begin
          if (wr_acc && paddr == branch_unit_pkg::REG_PC) begin
            pc_r <= pwdata[15:0];
          end else if (wr_acc && paddr == branch_unit_pkg::REG_CTRL
                       && pwdata[branch_unit_pkg::CTRL_GO]) begin
            busy_r <= 1'b1;
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
            pfetch_r <= 4'h0;
            cnt_r <= 3'd0;
            state_r <= branch_unit_pkg::S_FETCH;
          end
        end
        branch_unit_pkg::S_FETCH: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_addr_r <= pc_r + {13'h0000, cnt_r};
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            buf_r[cnt_r] <= mem_rdata;
            cnt_r <= cnt_r + 3'd1;
            len_r <= len_now;
            if (bad_now) begin
              illegal_r <= 1'b1;
              busy_r <= 1'b0;
              state_r <= branch_unit_pkg::S_IDLE;
            end else if (cnt_r + 3'd1 == len_now) begin
              state_r <= branch_unit_pkg::S_EVAL;
            end
          end
        end
        branch_unit_pkg::S_EVAL: begin
          if (op[7:4] == branch_unit_pkg::REL_GROUP) begin
            taken_r <= cond_ok;
            pc_r <= cond_ok ? target : seq_pc;
            qaddr_r <= cond_ok ? target : seq_pc;
            qleft_r <= cond_ok ? TAKEN_CNT : branch_unit_pkg::UNTAKEN_FETCHES;
            state_r <= branch_unit_pkg::S_QUEUE;
          end else begin
            state_r <= branch_unit_pkg::S_READ;
          end
        end
        branch_unit_pkg::S_READ: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_addr_r <= ea;
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            data_r <= mem_rdata;
            if (is_bsetop) begin
              mem_wdata_r <= mem_rdata | mask;
              state_r <= branch_unit_pkg::S_WRITE;
            end else begin
              taken_r <= bits_ok;
              pc_r <= bits_ok ? target : seq_pc;
              qaddr_r <= bits_ok ? target : seq_pc;
              qleft_r <= bits_ok ? TAKEN_CNT : branch_unit_pkg::UNTAKEN_FETCHES;
              state_r <= branch_unit_pkg::S_QUEUE;
            end
          end
        end
        branch_unit_pkg::S_WRITE: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b1;
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            pc_r <= seq_pc;
            qaddr_r <= seq_pc;
            qleft_r <= branch_unit_pkg::UNTAKEN_FETCHES;
            state_r <= branch_unit_pkg::S_QUEUE;
          end
        end
        branch_unit_pkg::S_QUEUE: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_qfill_r <= 1'b1;
            mem_addr_r <= qaddr_r;
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            mem_qfill_r <= 1'b0;
            qaddr_r <= qaddr_r + branch_unit_pkg::WORD_STEP;
            qleft_r <= qleft_r - 4'h1;
            pfetch_r <= pfetch_r + 4'h1;
            if (qleft_r == 4'h1) begin
              busy_r <= 1'b0;
              state_r <= branch_unit_pkg::S_IDLE;
            end
          end
        end
        default: state_r <= branch_unit_pkg::S_IDLE;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_qfill = mem_qfill_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence eval_op(logic [7:0] code);
    state_r == branch_unit_pkg::S_EVAL && op == code;
  endsequence

  a_flags_held: assert property (busy_r && $past(busy_r) |-> $stable(flags_r))
    else $error("Flags changed during execution");
  a_plus_taken: assert property (eval_op(branch_unit_pkg::OP_PLUS) |=>
    taken_r == !$past(flags_r[branch_unit_pkg::FLG_N]))
    else $error("Plus branch decision wrong");
  a_always_target: assert property (eval_op(branch_unit_pkg::OP_ALWAYS) |=>
    pc_r == $past(pc_r) + 16'h0002 + {{8{$past(buf_r[1][7])}}, $past(buf_r[1])})
    else $error("Branch always target wrong");
  a_always_refill: assert property (eval_op(branch_unit_pkg::OP_ALWAYS) |=>
    taken_r && qleft_r == TAKEN_CNT ##1 mem_req_r && mem_qfill_r && mem_addr_r == pc_r)
    else $error("Branch always refill wrong");
  a_never_step: assert property (eval_op(branch_unit_pkg::OP_NEVER) |=>
    pc_r == $past(pc_r) + branch_unit_pkg::PC_STEP && !taken_r && qleft_r == 4'h1)
    else $error("Branch never not a two-byte step");
  a_signed_gt: assert property (eval_op(branch_unit_pkg::OP_SGREATER) |=> taken_r ==
    !($past(flags_r[2]) | ($past(flags_r[3]) ^ $past(flags_r[1]))))
    else $error("Signed greater decision wrong");
  a_unsigned_hi: assert property (eval_op(branch_unit_pkg::OP_UHIGHER) |=>
    taken_r == !($past(flags_r[0]) | $past(flags_r[2])))
    else $error("Unsigned higher decision wrong");
  a_cleared_test: assert property (state_r == branch_unit_pkg::S_READ && ack_now
    && op[3:0] == branch_unit_pkg::LO_CLEARED |=> taken_r == (($past(mem_rdata) & mask) == 8'h00))
    else $error("Bits cleared decision wrong");
  a_set_test: assert property (state_r == branch_unit_pkg::S_READ && ack_now
    && op[3:0] == branch_unit_pkg::LO_SET |=> taken_r == ((~$past(mem_rdata) & mask) == 8'h00))
    else $error("Bits set decision wrong");
  a_bitset_write: assert property (state_r == branch_unit_pkg::S_WRITE && mem_req_r |->
    mem_we_r && mem_wdata_r == (data_r | mask) && mem_addr_r == ea)
    else $error("Bit set write data wrong");
  a_indirect_refused: assert property (state_r == branch_unit_pkg::S_FETCH && ack_now
    && cnt_r == 3'd1 && op[7:4] == branch_unit_pkg::MODE_IDX && mem_rdata[7:5] == 3'b111
    && mem_rdata[1:0] == 2'b11 |=> illegal_r && !busy_r)
    else $error("Indirect indexed form accepted");
endmodule : branch_unit

// ===== verification/mem_partner.sv
/*
  Byte-wide program and data memory answering the unit's memory port.
  Assumes requests are held until mem_ack; the bench sets the latency and
  loads bytes straight into store_r.
*/
`timescale 1ns/100ps
module mem_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_qfill,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  input wire logic [3:0] lat,
  input wire logic clr,
  output logic [7:0] qfill_cnt,
  output logic [15:0] first_qfill,
  output logic [7:0] wr_cnt,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [7:0] store_r [0:65535];
  logic [3:0] wait_r;
  // ==========================================================
  // Answer and record
  // Data lines toggle between answers so a stale byte never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_r <= 4'h0;
      qfill_cnt <= 8'h00;
      wr_cnt <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (clr) begin
        qfill_cnt <= 8'h00;
        wr_cnt <= 8'h00;
      end
      if (mem_req && !mem_ack) begin
        if (wait_r >= lat) begin
          mem_ack <= 1'b1;
          wait_r <= 4'h0;
          mem_rdata <= store_r[mem_addr];
          if (mem_we) begin
            store_r[mem_addr] <= mem_wdata;
            wr_cnt <= wr_cnt + 8'h01;
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
          end
          if (mem_qfill) begin
            qfill_cnt <= qfill_cnt + 8'h01;
            if (qfill_cnt == 8'h00) begin
              first_qfill <= mem_addr;
            end
          end
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule : mem_partner

// ===== verification/tb.sv
/*
  Self-checking bench for the branch and bit-test unit, one task per
  scenario. Assumes mem_partner on the memory port and APB at 25 MHz.
*/
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic mem_req, mem_we, mem_qfill, mem_ack, clr = 1'b0;
  logic [15:0] mem_addr, first_qfill, wr_addr;
  logic [7:0] mem_wdata, mem_rdata, qfill_cnt, wr_cnt, wr_data;
  logic [3:0] lat = 4'h0;
  int bad_count = 0;
  int n_compared = 0;

  always #20 pclk = ~pclk;

  branch_unit #(.TAKEN_FETCHES(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_qfill(mem_qfill), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_partner mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_qfill(mem_qfill), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat), .clr(clr), .qfill_cnt(qfill_cnt),
    .first_qfill(first_qfill), .wr_cnt(wr_cnt), .wr_addr(wr_addr), .wr_data(wr_data));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("BAD %0t no bus answer", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [15:0] a, input logic [47:0] code);
    for (int i = 0; i < 6; i++) begin
      mem_model.store_r[a + 16'(i)] = code[47 - 8 * i -: 8];
    end
  endtask : put

  // Flags f are {N, Z, V, C}; odd opcodes are the complement of the even ones
  function automatic logic cond(input logic [7:0] op, input logic [3:0] f);
    logic t;
    case (op[3:1])
      3'h0: t = 1'b1;
      3'h1: t = ~(f[0] | f[2]);
      3'h2: t = ~f[0];
      3'h3: t = ~f[2];
      3'h4: t = ~f[1];
      3'h5: t = ~f[3];
      3'h6: t = ~(f[3] ^ f[1]);
      default: t = ~(f[2] | (f[3] ^ f[1]));
    endcase
    return op[0] ? ~t : t;
  endfunction : cond

  // One instruction from PC, then status, PC, flags and bus traffic judged
  task automatic run(input logic [15:0] pc, input logic [7:0] fl, input logic [15:0] exp_pc,
      input logic tk, input logic ill, input logic wb);
    logic [3:0] nf;
    int n;
    nf = ill ? 4'h0 : (tk ? 4'h3 : 4'h1);
    apb(1'b1, branch_unit_pkg::REG_FLAGS, {24'h0, fl});
    apb(1'b1, branch_unit_pkg::REG_PC, {16'h0, pc});
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, branch_unit_pkg::REG_CTRL, 32'h1);
    n = 0;
    rdat = 32'h1;
    while (rdat[0] !== 1'b0 && n < 100) begin
      apb(1'b0, branch_unit_pkg::REG_STATUS, 32'h0);
      n++;
    end
    check(rdat, {24'h0, nf, 1'b0, ill, tk, 1'b0});
    apb(1'b0, branch_unit_pkg::REG_PC, 32'h0);
    check(rdat, {16'h0, exp_pc});
    apb(1'b0, branch_unit_pkg::REG_FLAGS, 32'h0);
    check(rdat, {24'h0, fl});
    check({24'h0, qfill_cnt}, {28'h0, nf});
    check({24'h0, wr_cnt}, {31'h0, wb});
    if (!ill) check({16'h0, first_qfill}, {16'h0, exp_pc});
  endtask : run

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    for (int i = 1; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rdat, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check({rdat[30:0], rerr}, 32'h1);
    apb(1'b1, 8'h06, 32'hffff);
    check({31'h0, rerr}, 32'h1);
  endtask : t_reset_values

  task automatic t_cond_table();
    logic [7:0] rr;
    logic [15:0] tgt;
    logic t;
    for (int op = 8'h20; op <= 8'h2f; op++) begin
      for (int f = 0; f < 16; f++) begin
        rr = f[0] ? 8'h85 : 8'h12;
        t = cond(8'(op), 4'(f));
        tgt = t ? 16'h3002 + {{8{rr[7]}}, rr} : 16'h3002;
        put(16'h3000, {8'(op), rr, 32'h0});
        run(16'h3000, {4'ha, 4'(f)}, tgt, t, 1'b0, 1'b0);
      end
    end
  endtask : t_cond_table

  task automatic t_wrap_and_slow();
    put(16'hfffe, {16'h2010, 32'h0});
    run(16'hfffe, 8'h00, 16'h0010, 1'b1, 1'b0, 1'b0);
    lat <= 4'h3;
    put(16'h5000, {16'h2080, 32'h0});
    run(16'h5000, 8'h0f, 16'h4f82, 1'b1, 1'b0, 1'b0);
    put(16'h5000, {16'h2180, 32'h0});
    run(16'h5000, 8'h0f, 16'h5002, 1'b0, 1'b0, 1'b0);
    lat <= 4'h0;
  endtask : t_wrap_and_slow

  task automatic bt(input logic [47:0] code, input logic [15:0] exp_pc, input logic tk,
      input logic ill);
    put(16'h4000, code);
    run(16'h4000, 8'h00, exp_pc, tk, ill, 1'b0);
  endtask : bt

  task automatic t_bit_tests();
    apb(1'b1, branch_unit_pkg::REG_INDEX, 32'h1000);
    mem_model.store_r[16'h0080] = 8'ha5;
    mem_model.store_r[16'h1005] = 8'ha5;
    mem_model.store_r[16'h1020] = 8'ha5;
    mem_model.store_r[16'h1100] = 8'ha5;
    bt(48'h4f805a100000, 16'h4014, 1'b1, 1'b0);
    bt(48'h4f8001100000, 16'h4004, 1'b0, 1'b0);
    bt(48'h4e8021100000, 16'h4014, 1'b1, 1'b0);
    bt(48'h4e8002100000, 16'h4004, 1'b0, 1'b0);
    bt(48'h1f00805af000, 16'h3ff5, 1'b1, 1'b0);
    bt(48'h1e0080021000, 16'h4005, 1'b0, 1'b0);
    bt(48'h0f055a100000, 16'h4014, 1'b1, 1'b0);
    bt(48'h0ee020211000, 16'h4015, 1'b1, 1'b0);
    bt(48'h0fe201005a10, 16'h4016, 1'b1, 1'b0);
    bt(48'h0ee201000210, 16'h4006, 1'b0, 1'b0);
    bt(48'h0fe301005a10, 16'h4000, 1'b0, 1'b1);
    bt(48'h0ce742000000, 16'h4000, 1'b0, 1'b1);
  endtask : t_bit_tests

  task automatic bs(input logic [47:0] code, input logic [15:0] exp_pc,
      input logic [15:0] ea, input logic [7:0] val);
    put(16'h4000, code);
    run(16'h4000, 8'h00, exp_pc, 1'b0, 1'b0, 1'b1);
    check({16'h0, wr_addr}, {16'h0, ea});
    check({24'h0, wr_data}, {24'h0, val});
  endtask : bs

  task automatic t_bit_set();
    mem_model.store_r[16'h0090] = 8'ha5;
    bs(48'h4c9042000000, 16'h4003, 16'h0090, 8'he7);
    bs(48'h1c1020180000, 16'h4004, 16'h1020, 8'hbd);
    bs(48'h0c050a000000, 16'h4003, 16'h1005, 8'haf);
    bs(48'h0ce201005000, 16'h4005, 16'h1100, 8'hf5);
  endtask : t_bit_set

  // ==========================================================
  // Verdict and sequencing
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_cond_table();
    t_wrap_and_slow();
    t_bit_tests();
    t_bit_set();
    wrap_up();
  end

  // Roughly five times the expected run length
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule : tb
